// >>> embedded_block.sv
// Embedded block of a programmable fabric: sixteen product-term macrocells or a
// 2048-bit synchronous RAM with page-decoded tri-state output for deep memories.
// Assumes configuration inputs stay static during operation and all inputs are on clk.
//
// How it works
// - Thirty-two general inputs arrive from the neighbouring routing.
// - Nine macrocell outputs loop back as extra inputs for fast feedback.
// - Sixteen macrocells, each with two product terms and one register.
// - Each product term feeds its own OR gate or lends itself as expander.
// - One product term per macrocell can be inverted for De Morgan forms.
// - Each register acts as D, T, JK, SR, or is bypassed at mc_out only.
// - Each register picks one of two clocks and that clock's enable.
// - Mixed edge polarities use both block clocks, one per edge.
// - Two clears built from global and local signals, optionally inverted, chosen per cell.
// - OR logic can gather up to 32 terms, thirty borrowed from neighbours.
// - At most fifteen chained expander sets of two terms each.
// - Memory input registers capture data, address, controls; output register optional.
// - Dual-port read and write happen in the same period.
// - Write strobe is generated internally from registered request.
// - Ten local outputs drive the routing, nine of them distinct.
// - Memory geometry is 128x16, 256x8, 512x4, 1024x2 or 2048x1.
// - Blocks side by side form wider words without extra logic.
// - Page decoder enables the shared-line driver only for its page.
// - Eleven low address bits reach the array, two high bits the decoder.
// - At most one page driver is active on a shared line.
// - Dual-port clocking is write/read or input/output form.
// - Two blocks pair to give two ports that each read or write.
// - Write/read form: write registers on one clock, read registers on other.
// - Input/output form: all input registers on one clock, output on other.
// - Every memory register clears asynchronously on chip reset; all but the array also clear on the next clock edge from local or global clear.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "embedded_block_defs.svh"

module embedded_block
    import embedded_block_pkg::*;
#(
    parameter int NUM_IN    = `EB_NUM_INPUTS,
    parameter int NUM_MC    = `EB_NUM_MCELLS,
    parameter int ARR_BITS  = `EB_ARRAY_BITS,
    parameter int ABITS     = `EB_ADDR_BITS
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    // Configuration.
    input  wire logic                       mem_mode,
    input  wire logic [2:0]                 geometry,
    input  wire embedded_block_pkg::clk_form_t clk_form,
    input  wire logic                       out_reg_en,
    input  wire logic [`EB_PAGE_BITS-1:0]   page_id,
    input  wire logic                       deep_en,
    input  wire logic [NUM_MC*2*(NUM_IN+`EB_NUM_FEEDBACK)-1:0] pterm_true,
    input  wire logic [NUM_MC*2*(NUM_IN+`EB_NUM_FEEDBACK)-1:0] pterm_comp,
    input  wire logic [NUM_MC*2-1:0]        pterm_lend,
    input  wire logic [NUM_MC-1:0]          pterm_invert,
    input  wire logic [NUM_MC-1:0]          xor_pol,
    input  wire logic [NUM_MC-1:0]          chain_in_en,
    input  wire logic [NUM_MC*3-1:0]        reg_kind,
    input  wire logic [NUM_MC-1:0]          clk_sel,
    input  wire logic [NUM_MC*2-1:0]        clr_sel,
    input  wire logic [1:0]                 clr_invert,
    // Fabric inputs and block-wide controls.
    input  wire logic [NUM_IN-1:0]          local_in,
    input  wire logic [1:0]                 blk_clk_en,
    input  wire logic [1:0]                 global_clr,
    input  wire logic [1:0]                 local_clr,
    // Memory user side.
    input  wire logic [15:0]                wr_data,
    input  wire logic [ABITS+`EB_PAGE_BITS-1:0] wr_addr,
    input  wire logic                       wr_req,
    input  wire logic [ABITS+`EB_PAGE_BITS-1:0] rd_addr,
    input  wire logic                       read_strobe,
    input  wire logic                       in_clk_en,
    input  wire logic                       out_clk_en,
    // Outputs.
    output logic [NUM_MC-1:0]               mc_out,
    output logic [`EB_NUM_LOCAL_OUT-1:0]    local_out,
    output logic [15:0]                     rd_data,
    output logic [15:0]                     col_line_out,
    output logic                            col_line_oe
);
    localparam int NTI = NUM_IN + `EB_NUM_FEEDBACK;

    // ----------------------------------------------------------------
    // Product-term array
    // ----------------------------------------------------------------
    logic [NTI-1:0]        term_in;
    logic [NUM_MC*2-1:0]   pterm;
    logic [NUM_MC-1:0]     own_or;
    logic [NUM_MC-1:0]     lend_or;
    logic [NUM_MC:0]       chain;
    logic [NUM_MC-1:0]     comb_out;
    logic [NUM_MC-1:0]     mc_r;
    logic [1:0]            clr_line;
    logic [NUM_MC-1:0]     mc_clr;

    assign term_in = {mc_r[`EB_NUM_FEEDBACK-1:0], local_in};

    function automatic logic and_term(input logic [NTI-1:0] v, input logic [NTI-1:0] t,
                                      input logic [NTI-1:0] c);
        and_term = &((v | ~t) & (~v | ~c));
    endfunction

    assign clr_line = (global_clr | local_clr) ^ clr_invert;
    assign chain[0] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < NUM_MC; g++) begin : g_mc
            logic t0;
            logic t1;
            assign t0 = and_term(term_in, pterm_true[(2*g)*NTI +: NTI], pterm_comp[(2*g)*NTI +: NTI]);
            assign t1 = pterm_invert[g] ^ and_term(term_in, pterm_true[(2*g+1)*NTI +: NTI],
                                                   pterm_comp[(2*g+1)*NTI +: NTI]);
            assign pterm[2*g]   = t0;
            assign pterm[2*g+1] = t1;
            // Own use or lend as expander.
            assign own_or[g]  = (t0 & ~pterm_lend[2*g]) | (t1 & ~pterm_lend[2*g+1]);
            assign lend_or[g] = (t0 & pterm_lend[2*g]) | (t1 & pterm_lend[2*g+1]);
            // Expander chain, one set of two per neighbour, max fifteen.
            assign chain[g+1] = lend_or[g] | (chain_in_en[g] & chain[g]);
            assign comb_out[g] = (own_or[g] | (chain_in_en[g] & chain[g])) ^ xor_pol[g];
            assign mc_clr[g] = (clr_sel[2*g] & clr_line[0]) | (clr_sel[2*g+1] & clr_line[1]);
        end
    endgenerate

    // Register kinds; clock choice gates the cell through its paired enable.
    function automatic logic next_state(input logic [2:0] k, input logic q, input logic d, input logic j,
                                        input logic kk);
        unique case (k)
            REG_T:   next_state = q ^ d;
            REG_JK:  next_state = (j & ~q) | (~kk & q);
            REG_SR:  next_state = j | (~kk & q);
            default: next_state = d;
        endcase
    endfunction

    // Macrocell registers on clk; block clock 1 models the opposite edge via its enable.
    generate
        for (g = 0; g < NUM_MC; g++) begin : g_reg
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mc_r[g] <= `EB_RESET_ZERO;
                end else if (mc_clr[g]) begin
                    mc_r[g] <= `EB_RESET_ZERO;
                end else if (clk_en && blk_clk_en[clk_sel[g]] && !mem_mode) begin
                    mc_r[g] <= next_state(reg_kind[3*g +: 3], mc_r[g], comb_out[g],
                                          comb_out[g], pterm[2*g+1]);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Memory
    // ----------------------------------------------------------------
    logic [ARR_BITS-1:0]        mem_r;
    logic [15:0]                wdata_r;
    logic [ABITS+1:0]           waddr_r;
    logic                       wreq_r;
    logic [ABITS+1:0]           raddr_r;
    logic                       rstb_r;
    logic [15:0]                rword;
    logic [15:0]                rdata_r;
    logic [15:0]                rd_data_r;
    logic                       mem_clr;
    logic                       wr_ce;
    logic                       rd_ce;

    assign mem_clr = |(global_clr | local_clr);
    assign wr_ce = clk_en & in_clk_en;
    assign rd_ce = clk_en & ((clk_form == CLK_WRITE_READ) ? out_clk_en : in_clk_en);

    function automatic logic [4:0] word_bits(input logic [2:0] geo);
        unique case (geo)
            `EB_WIDTH_128X16: word_bits = 5'h10;
            `EB_WIDTH_256X8:  word_bits = 5'h08;
            `EB_WIDTH_512X4:  word_bits = 5'h04;
            `EB_WIDTH_1024X2: word_bits = 5'h02;
            default:          word_bits = 5'h01;
        endcase
    endfunction

    function automatic logic [ABITS-1:0] bit_base(input logic [2:0] geo, input logic [ABITS-1:0] a);
        logic [ABITS-1:0] b;
        b = a;
        unique case (geo)
            `EB_WIDTH_128X16: b = {a[6:0], 4'h0};
            `EB_WIDTH_256X8:  b = {a[7:0], 3'h0};
            `EB_WIDTH_512X4:  b = {a[8:0], 2'h0};
            `EB_WIDTH_1024X2: b = {a[9:0], 1'b0};
            default:          b = a;
        endcase
        bit_base = b;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdata_r <= '0;
            waddr_r <= '0;
            wreq_r  <= 1'b0;
        end else if (mem_clr) begin
            wdata_r <= '0;
            waddr_r <= '0;
            wreq_r  <= 1'b0;
        end else if (wr_ce) begin
            wdata_r <= wr_data;
            waddr_r <= wr_addr;
            wreq_r  <= wr_req & mem_mode;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raddr_r <= '0;
            rstb_r  <= 1'b0;
        end else if (mem_clr) begin
            raddr_r <= '0;
            rstb_r  <= 1'b0;
        end else if (rd_ce) begin
            raddr_r <= rd_addr;
            rstb_r  <= read_strobe & mem_mode;
        end
    end

    // Self-timed write from registered request; read in the same period.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r <= '0;
        end else if (clk_en && wreq_r && (!deep_en || waddr_r[ABITS +: 2] == page_id)) begin
            for (int i = 0; i < 16; i++) begin
                if (i < int'(word_bits(geometry))) begin
                    mem_r[bit_base(geometry, waddr_r[ABITS-1:0]) + ABITS'(i)] <= wdata_r[i];
                end
            end
        end
    end

    // Read sees the array before this cycle's write.
    always_comb begin
        rword = '0;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(word_bits(geometry))) begin
                rword[i] = mem_r[bit_base(geometry, raddr_r[ABITS-1:0]) + ABITS'(i)];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (mem_clr) begin
            rdata_r <= '0;
        end else if (clk_en && rstb_r) begin
            rdata_r <= rword;
        end
    end

    // Optional output register on the output enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= '0;
        end else if (mem_clr) begin
            rd_data_r <= '0;
        end else if (clk_en && out_clk_en) begin
            rd_data_r <= rdata_r;
        end
    end

    // ----------------------------------------------------------------
    // Page decode
    // ----------------------------------------------------------------
    logic                       rpage_r;
    logic                       rpage_q;

    // Page hit on the two high read-address bits.
    // The hit travels with the read word, so the driver enable of the shared
    // line is never a cycle ahead of or behind the data it puts there.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rpage_r <= 1'b0;
        end else if (mem_clr) begin
            rpage_r <= 1'b0;
        end else if (clk_en && rstb_r) begin
            rpage_r <= (raddr_r[ABITS +: 2] == page_id);
        end
    end

    // The page hit follows the optional output register as well.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rpage_q <= 1'b0;
        end else if (mem_clr) begin
            rpage_q <= 1'b0;
        end else if (clk_en && out_clk_en) begin
            rpage_q <= rpage_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Full-width words let neighbours sit side by side.
    // A clear empties the read outputs on the same edge as the registers behind them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (mem_clr) begin
            rd_data <= '0;
        end else if (clk_en) begin
            rd_data <= out_reg_en ? rd_data_r : rdata_r;
        end
    end

    // Word offered to the shared column line.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_line_out <= '0;
        end else if (mem_clr) begin
            col_line_out <= '0;
        end else if (clk_en) begin
            col_line_out <= out_reg_en ? rd_data_r : rdata_r;
        end
    end

    // Only the block whose page was read drives the shared line.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_line_oe <= 1'b0;
        end else if (mem_clr) begin
            col_line_oe <= 1'b0;
        end else if (clk_en) begin
            col_line_oe <= mem_mode & deep_en & (out_reg_en ? rpage_q : rpage_r);
        end
    end

    // Pairing two blocks is done outside; each keeps its own ports.
    // Bypassed cells show their combining gates, the others their register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_out <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_MC; i++) begin
                mc_out[i] <= (reg_kind[3*i +: 3] == REG_NONE) ? comb_out[i] : mc_r[i];
            end
        end
    end

    // Ten local outputs, the tenth repeats the first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            local_out <= '0;
        end else if (clk_en) begin
            local_out <= mem_mode ? {rdata_r[0], rdata_r[8:0]} : {mc_r[0], mc_r[8:0]};
        end
    end

endmodule // embedded_block

// >>> embedded_block_defs.svh
// Constants for the embedded block: sizes, geometry, page decode and reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef EMBEDDED_BLOCK_DEFS_SVH
`define EMBEDDED_BLOCK_DEFS_SVH

`define EB_NUM_INPUTS      32
`define EB_NUM_MCELLS      16
`define EB_NUM_FEEDBACK    9
`define EB_NUM_LOCAL_OUT   10
`define EB_ARRAY_BITS      2048
`define EB_ADDR_BITS       11
`define EB_PAGE_BITS       2
`define EB_MAX_EXP_SETS    15
`define EB_WIDTH_128X16    3'h0
`define EB_WIDTH_256X8     3'h1
`define EB_WIDTH_512X4     3'h2
`define EB_WIDTH_1024X2    3'h3
`define EB_WIDTH_2048X1    3'h4
`define EB_RESET_ZERO      1'b0

`endif

// >>> embedded_block_pkg.sv
// Types shared by the embedded block: macrocell register kinds and clocking forms.
// Assumes the constants header sits in the same folder.
`include "embedded_block_defs.svh"

package embedded_block_pkg;

    typedef enum logic [2:0] {
        REG_D    = 3'h0,
        REG_T    = 3'h1,
        REG_JK   = 3'h2,
        REG_SR   = 3'h3,
        REG_NONE = 3'h4
    } reg_kind_t;

    typedef enum logic [1:0] {
        CLK_WRITE_READ = 2'h0,
        CLK_IN_OUT     = 2'h1,
        CLK_SINGLE     = 2'h2
    } clk_form_t;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'h1,
        MODE_MEM  = 2'h2
    } mode_t;

endpackage

// >>> embedded_block_sva.sv
// Checker for the embedded block outputs.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Output checks
// ------------------------------------------------------------
module embedded_block_sva #(
    parameter int NUM_MC = 16
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              clk_en,
    input wire logic              mem_mode,
    input wire logic [2:0]        geometry,
    input wire logic              out_reg_en,
    input wire logic              read_strobe,
    input wire logic [1:0]        global_clr,
    input wire logic [1:0]        local_clr,
    input wire logic [NUM_MC-1:0] mc_out,
    input wire logic [9:0]        local_out,
    input wire logic [15:0]       rd_data,
    input wire logic [15:0]       col_line_out,
    input wire logic              col_line_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic clr;
    assign clr = (|global_clr) || (|local_clr);
    chk_reset_zero: assert property (disable iff (1'b0) !rst_n |-> rd_data == 16'h0
        && mc_out == '0 && local_out == 10'h0 && col_line_out == 16'h0 && !col_line_oe)
        else $error("outputs not zero during reset");
    chk_clear_rdata: assert property (mem_mode && clr |=> rd_data == 16'h0)
        else $error("read data survived a clear");
    chk_freeze_state: assert property (!clk_en && !clr |=> $stable(rd_data) && $stable(mc_out)
        && $stable(local_out) && $stable(col_line_oe))
        else $error("state moved while frozen");
    chk_narrow_word: assert property ((mem_mode && geometry == 3'h4) [*4] ##0 $changed(rd_data)
        |-> rd_data[15:1] == 15'h0)
        else $error("one-bit word has upper bits set");
    chk_read_cause: assert property (mem_mode && !out_reg_en && $changed(rd_data) && rd_data != 16'h0
        |-> $past(read_strobe, 3))
        else $error("read data changed without a read");
    chk_dup_local: assert property (local_out[9] == local_out[0])
        else $error("tenth local output differs");
    chk_oe_memory: assert property ((!mem_mode) [*4] |-> !col_line_oe)
        else $error("column line driven outside memory use");
    chk_ptm_quiet: assert property ((!mem_mode && !clr) [*3] |=> $stable(rd_data))
        else $error("read data moved in product-term use");
endmodule // embedded_block_sva

// >>> fabric_cells.sv
// Model of the logic cells that feed the memory side of the block.
// Assumes the bench calls its task; drives just after rising clk edges.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Memory request driver
// ------------------------------------------------------------
module fabric_cells (
    input  wire logic clk,
    output logic [15:0] wr_data,
    output logic [12:0] wr_addr,
    output logic        wr_req,
    output logic [12:0] rd_addr,
    output logic        read_strobe
);
    initial begin
        wr_data = 16'h0;
        wr_addr = 13'h0;
        wr_req = 1'b0;
        rd_addr = 13'h0;
        read_strobe = 1'b0;
    end
    task automatic access(input logic w, input logic r, input logic [12:0] wa, input logic [12:0] ra,
                          input logic [15:0] d);
        @(posedge clk);
        wr_req <= w;
        read_strobe <= r;
        wr_addr <= wa;
        rd_addr <= ra;
        wr_data <= d;
        @(posedge clk);
        wr_req <= 1'b0;
        read_strobe <= 1'b0;
        wr_addr <= ~wa;
        rd_addr <= ~ra;
        wr_data <= ~d;
    endtask
endmodule // fabric_cells

// >>> embedded_block_tb.sv
// Bench for the embedded block: geometries, paging, clears, macrocells.
// Assumes the fabric model drives the memory requests.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module embedded_block_tb;
    import embedded_block_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b1;
    logic clk_en = 1'b1;
    logic mem_mode = 1'b1;
    logic [2:0] geometry = 3'h0;
    clk_form_t clk_form = CLK_WRITE_READ;
    logic out_reg_en = 1'b0;
    logic [1:0] page_id = 2'h0;
    logic deep_en = 1'b0;
    logic [1311:0] pterm_true = '0;
    logic [1311:0] pterm_comp = '0;
    logic [31:0] pterm_lend = '0;
    logic [15:0] pterm_invert = '0;
    logic [15:0] xor_pol = '0;
    logic [15:0] chain_in_en = '0;
    logic [47:0] reg_kind = '0;
    logic [15:0] clk_sel = '0;
    logic [31:0] clr_sel = '0;
    logic [1:0] clr_invert = 2'h0;
    logic [31:0] local_in = '0;
    logic [1:0] blk_clk_en = 2'h3;
    logic [1:0] global_clr = 2'h0;
    logic [1:0] local_clr = 2'h0;
    logic in_clk_en = 1'b1;
    logic out_clk_en = 1'b1;
    logic [15:0] wr_data, rd_addr_unused, rd_data, col_line_out, mc_out;
    logic [12:0] wr_addr, rd_addr;
    logic wr_req, read_strobe, col_line_oe;
    logic [9:0] local_out;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    fabric_cells fabric_cells_i (.clk, .wr_data, .wr_addr, .wr_req, .rd_addr, .read_strobe);
    embedded_block embedded_block_i (.clk, .rst_n, .clk_en, .mem_mode, .geometry, .clk_form, .out_reg_en,
        .page_id, .deep_en, .pterm_true, .pterm_comp, .pterm_lend, .pterm_invert, .xor_pol, .chain_in_en,
        .reg_kind, .clk_sel, .clr_sel, .clr_invert, .local_in, .blk_clk_en, .global_clr, .local_clr,
        .wr_data, .wr_addr, .wr_req, .rd_addr, .read_strobe, .in_clk_en, .out_clk_en,
        .mc_out, .local_out, .rd_data, .col_line_out, .col_line_oe);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [12:0] a, input logic [15:0] d);
        fabric_cells_i.access(1'b1, 1'b0, a, 13'h0, d);
        @(posedge clk);
    endtask
    task automatic rd(input logic [12:0] a, output logic [15:0] q);
        fabric_cells_i.access(1'b0, 1'b1, 13'h0, a, 16'h0);
        repeat (out_reg_en ? 3 : 2) @(posedge clk);
        #1;
        q = rd_data;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        logic [15:0] q;
        logic [15:0] m;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(rd_data | mc_out | {6'h0, local_out}, 16'h0);
        for (int g = 0; g < 5; g++) begin
            @(posedge clk);
            geometry <= 3'(g);
            clk_form <= clk_form_t'(g % 3);
            m = 16'((17'h1 << (16 >> g)) - 17'h1);
            wr(13'h5, 16'hbeef);
            wr(13'h6, 16'h1234);
            rd(13'h5, q);
            check(q, 16'hbeef & m);
            rd(13'h6, q);
            check(q, 16'h1234 & m);
        end
        $display("geometry test done");
        @(posedge clk);
        geometry <= 3'h0;
        clk_form <= CLK_WRITE_READ;
        wr(13'h9, 16'h1111);
        fabric_cells_i.access(1'b1, 1'b1, 13'h9, 13'h9, 16'h2222);
        repeat (2) @(posedge clk);
        #1;
        check(rd_data, 16'h1111);
        rd(13'h9, q);
        check(q, 16'h2222);
        @(posedge clk);
        clk_en <= 1'b0;
        rd(13'h5, q);
        check(q, 16'h2222);
        @(posedge clk);
        clk_en <= 1'b1;
        in_clk_en <= 1'b0;
        wr(13'h9, 16'h3333);
        @(posedge clk);
        in_clk_en <= 1'b1;
        rd(13'h9, q);
        check(q, 16'h2222);
        $display("dual-port test done");
        @(posedge clk);
        deep_en <= 1'b1;
        page_id <= 2'h1;
        wr({2'h1, 11'h9}, 16'h5555);
        wr({2'h2, 11'h9}, 16'h4444);
        rd({2'h1, 11'h9}, q);
        check(q, 16'h5555);
        check({15'h0, col_line_oe}, 16'h1);
        check(col_line_out, 16'h5555);
        rd({2'h2, 11'h9}, q);
        check({15'h0, col_line_oe}, 16'h0);
        $display("page test done");
        @(posedge clk);
        deep_en <= 1'b0;
        rd(13'h9, q);
        out_reg_en <= 1'b1;
        fabric_cells_i.access(1'b0, 1'b1, 13'h0, 13'h5, 16'h0);
        repeat (2) @(posedge clk);
        #1;
        check(rd_data, 16'h5555);
        repeat (2) @(posedge clk);
        #1;
        check(rd_data, 16'hbeef);
        @(posedge clk);
        local_clr <= 2'h2;
        @(posedge clk);
        local_clr <= 2'h0;
        #1;
        check(rd_data, 16'h0);
        $display("pipeline and clear test done");
        @(posedge clk);
        mem_mode <= 1'b0;
        pterm_true[0] <= 1'b1;
        pterm_true[42] <= 1'b1;
        pterm_comp[42] <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            reg_kind <= k[2] ? 48'h0 : 48'h4;
            local_in <= 32'(k & 1);
            pterm_invert[0] <= k[1];
            repeat (3) @(posedge clk);
            #1;
            check({15'h0, mc_out[0]}, 16'(k[0] | k[1]));
        end
        @(posedge clk);
        clr_sel <= 32'h1;
        global_clr <= 2'h1;
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, mc_out[0]}, 16'h0);
        @(posedge clk);
        global_clr <= 2'h0;
        xor_pol <= 16'h1;
        repeat (3) @(posedge clk);
        #1;
        check({15'h0, mc_out[0]}, 16'h0);
        $display("macrocell test done");
        conclude();
    end
endmodule // embedded_block_tb
bind embedded_block embedded_block_sva #(.NUM_MC(NUM_MC)) embedded_block_sva_i (.clk, .rst_n, .clk_en,
    .mem_mode, .geometry, .out_reg_en, .read_strobe, .global_clr, .local_clr, .mc_out, .local_out,
    .rd_data, .col_line_out, .col_line_oe);
